// *** pmr_mgmt_monitor.sv ***
// Checker for the management port and shared pin block.
`timescale 1ns/1ps
`default_nettype none
module pmr_mgmt_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        resetN,
	input wire logic        mdc,
	input wire logic        mdioOut,
	input wire logic        mdioOe,
	input wire logic        irqOrSleepPinOut,
	input wire logic        irqOrSleepPinOe,
	input wire logic [15:0] eventIn,
	input wire logic        powerDown,
	input wire logic        deviceReset
);
	int lowCnt = 0;
	int oeCnt = 0;
	always @(posedge clk) begin
		lowCnt <= resetN ? 0 : lowCnt + 1;
		oeCnt <= mdioOe ? oeCnt + 1 : 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_pin_not_high: assert property (!irqOrSleepPinOut)
		else $error("pin high");
	a_idle_zero: assert property (!mdioOe |-> !mdioOut)
		else $error("data while idle");
	a_oe_at_fall: assert property (
		$changed(mdioOe) |-> !$past(mdc, 2)) else $error("oe off fall");
	a_read_length: assert property (oeCnt <= 140)
		else $error("read too long");
	a_reset_holds: assert property (
		lowCnt > 24 |-> deviceReset) else $error("reset missed");
	a_reset_quiet: assert property (
		deviceReset ##1 deviceReset |-> !mdioOe && !irqOrSleepPinOe)
		else $error("drive in reset");
	a_irq_cause: assert property (
		$rose(irqOrSleepPinOe) |-> $past(|eventIn) || $past(|eventIn, 2))
		else $error("irq without event");
	a_irq_no_sleep: assert property (
		irqOrSleepPinOe [*4] |-> !powerDown) else $error("irq slept");
	c_read: cover property ($fell(mdioOe));
	c_irq: cover property ($rose(irqOrSleepPinOe));
	c_sleep: cover property ($rose(powerDown));
endmodule
`default_nettype wire

// *** pmr_mgmt_pins.v ***
// Management serial port, hardware reset and shared interrupt/sleep pin.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_regs.vh"

// How it works
// - Management clock accepted at any rate below half the clk rate (10MHz at 50ns), no lower limit.
// - Management clock is sampled, so no relation to MAC clocks is needed.
// - Data line driven by station or by us in turn, released otherwise.
// - After reset the shared pin is the power-down input.
// - Pin low in power-down role puts the transceiver into power-down.
// - Management reads and writes still work while powered down.
// - In interrupt role a pending unmasked interrupt pulls the pin low.
// - Interrupt pin is open-drain: pulled low or released, never high.
// - Pin role changes only by a management register write or a reset.
// - Active-low reset returns the frame engine and the register file to their defaults.
module pmr_mgmt_pins #(
	parameter [15:0] ID1         = 16'h1234, // Arbitrary value.
	parameter [15:0] ID2         = 16'h5678, // Arbitrary value.
	parameter integer RST_MIN_CYC = `PMR_RST_MIN_CYC
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        resetN,
	input  wire [4:0]  phyAddr,
	input  wire        mdc,
	input  wire        mdioIn,
	output reg         mdioOut,
	output reg         mdioOe,
	input  wire        irqOrSleepPinIn,
	output wire        irqOrSleepPinOut,
	output wire        irqOrSleepPinOe,
	input  wire [15:0] statusIn,
	input  wire [15:0] eventIn,
	output reg         powerDown,
	output reg         deviceReset
);
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_START = 3'h1;
	localparam [2:0] S_HDR   = 3'h2;
	localparam [2:0] S_TA    = 3'h3;
	localparam [2:0] S_DATA  = 3'h4;
	localparam [7:0] rstMin  = RST_MIN_CYC[7:0];

	wire [3:0] syncOut;
	wire       mdcSync;
	wire       mdioSync;
	wire       resetNSync;
	wire       pinSync;

	// The reference input is no port here: clk stands in for it.
	pmr_sync #(
		.WIDTH     (4),
		.RESET_VAL (1'b1)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({mdc, mdioIn, resetN, irqOrSleepPinIn}),
		.q     (syncOut)
	);
	assign mdcSync    = syncOut[3];
	assign mdioSync   = syncOut[2];
	assign resetNSync = syncOut[1];
	assign pinSync    = syncOut[0];

	reg        mdcLast;
	reg [7:0]  lowCount;
	reg        hwReset;
	reg [2:0]  state;
	reg [5:0]  cnt;
	reg [15:0] shift;
	reg        isRead;
	reg        isWrite;
	reg [15:0] rdData;
	reg        wrStb;
	reg [4:0]  wrAddr;
	reg [15:0] wrData;
	reg        rdClr;
	reg [15:0] ctrl;
	reg [15:0] irqMask;
	reg [15:0] irqStat;
	reg [15:0] pinCfg;
	reg [15:0] readMux;
	wire       mdcRise;
	wire       mdcFall;
	wire       regReset;
	wire       irqMode;
	wire       irqPending;

	// Edges come from the synchronised copy, so the management clock may be
	// unrelated to every other clock; its top rate is bounded by sampling.
	assign mdcRise = mdcSync & ~mdcLast;
	assign mdcFall = ~mdcSync & mdcLast;

	// Short glitches on the reset pin are ignored until the minimum width.
	always @(posedge clk) begin
		if (reset) begin
			mdcLast  <= 1'b1;
			lowCount <= 8'h00;
			hwReset  <= 1'b0;
		end else begin
			mdcLast <= mdcSync;
			if (resetNSync) begin
				lowCount <= 8'h00;
				hwReset  <= 1'b0;
			end else if (lowCount >= rstMin - 8'h01) begin
				hwReset <= 1'b1;
			end else begin
				lowCount <= lowCount + 8'h01;
			end
		end
	end

	assign regReset = reset | hwReset | ctrl[`PMR_CTRL_SOFT_RST];

	always @* begin
		case (shift[4:0])
		`PMR_REG_CTRL:     readMux = ctrl;
		`PMR_REG_STATUS:   readMux = statusIn;
		`PMR_REG_ID1:      readMux = ID1;
		`PMR_REG_ID2:      readMux = ID2;
		`PMR_REG_IRQ_MASK: readMux = irqMask;
		`PMR_REG_IRQ_STAT: readMux = irqStat;
		`PMR_REG_PIN_CFG:  readMux = pinCfg;
		default:           readMux = 16'h0000;
		endcase
	end

	// Frame engine; it never looks at powerDown so it keeps serving.
	always @(posedge clk) begin
		if (reset | hwReset) begin
			state   <= S_IDLE;
			cnt     <= 6'h00;
			shift   <= 16'h0000;
			isRead  <= 1'b0;
			isWrite <= 1'b0;
			rdData  <= 16'h0000;
			wrStb   <= 1'b0;
			wrAddr  <= 5'h00;
			wrData  <= 16'h0000;
			rdClr   <= 1'b0;
			mdioOut <= 1'b0;
			mdioOe  <= 1'b0;
		end else begin
			wrStb <= 1'b0;
			rdClr <= 1'b0;
			if (mdcRise) begin
				case (state)
				S_IDLE: begin
					if (mdioSync) begin
						if (cnt < `PMR_PREAMBLE_BITS)
							cnt <= cnt + 6'h01;
					end else if (cnt >= `PMR_PREAMBLE_BITS) begin
						state <= S_START;
						cnt   <= 6'h00;
					end else begin
						cnt <= 6'h00;
					end
				end
				S_START: begin
					state <= mdioSync ? S_HDR : S_IDLE;
					cnt   <= 6'h00;
				end
				S_HDR: begin
					shift <= {shift[14:0], mdioSync};
					if (cnt == `PMR_HDR_LAST) begin
						state   <= S_TA;
						cnt     <= 6'h00;
						isRead  <= (shift[10:9] == `PMR_OP_READ) &&
						           (shift[8:4] == phyAddr);
						isWrite <= (shift[10:9] == `PMR_OP_WRITE) &&
						           (shift[8:4] == phyAddr);
					end else begin
						cnt <= cnt + 6'h01;
					end
				end
				S_TA: begin
					if (cnt == 6'h00 && isRead) begin
						rdData <= readMux;
						rdClr  <= (shift[4:0] == `PMR_REG_IRQ_STAT);
					end
					if (cnt == 6'h00)
						wrAddr <= shift[4:0];
					if (cnt == `PMR_TA_LAST) begin
						state <= S_DATA;
						cnt   <= 6'h00;
					end else begin
						cnt <= cnt + 6'h01;
					end
				end
				S_DATA: begin
					shift <= {shift[14:0], mdioSync};
					if (cnt == `PMR_DATA_LAST) begin
						state  <= S_IDLE;
						cnt    <= 6'h00;
						wrStb  <= isWrite;
						wrData <= {shift[14:0], mdioSync};
						isRead <= 1'b0;
					end else begin
						cnt <= cnt + 6'h01;
					end
				end
				default: begin
					state <= S_IDLE;
					cnt   <= 6'h00;
				end
				endcase
			end
			// We drive only the second turnaround bit and the read data.
			if (mdcFall) begin
				if (isRead && state == S_TA && cnt == `PMR_TA_LAST) begin
					mdioOe  <= 1'b1;
					mdioOut <= 1'b0;
				end else if (isRead && state == S_DATA) begin
					mdioOe  <= 1'b1;
					mdioOut <= rdData[4'hF - cnt[3:0]];
				end else begin
					mdioOe  <= 1'b0;
					mdioOut <= 1'b0;
				end
			end
		end
	end

	// Register file; an event in the cycle of a clearing read is kept.
	always @(posedge clk) begin
		if (regReset) begin
			ctrl    <= `PMR_CTRL_RESET;
			irqMask <= `PMR_MASK_RESET;
			irqStat <= `PMR_STAT_RESET;
			pinCfg  <= `PMR_PIN_CFG_RESET;
		end else begin
			irqStat <= (rdClr ? 16'h0000 : irqStat) | eventIn;
			if (wrStb) begin
				case (wrAddr)
				`PMR_REG_CTRL:     ctrl    <= wrData;
				`PMR_REG_IRQ_MASK: irqMask <= wrData;
				`PMR_REG_PIN_CFG:  pinCfg  <= wrData;
				default:           ctrl    <= ctrl;
				endcase
			end
		end
	end

	assign irqMode    = pinCfg[`PMR_PIN_CFG_IRQ];
	assign irqPending = |(irqStat & irqMask);

	// Open drain: the output level is fixed low and only the enable moves.
	assign irqOrSleepPinOut = 1'b0;
	assign irqOrSleepPinOe  = irqMode & irqPending;

	always @(posedge clk) begin
		if (reset) begin
			powerDown   <= 1'b0;
			deviceReset <= 1'b1;
		end else begin
			powerDown   <= ctrl[`PMR_CTRL_PWRDN] |
			               (~irqMode & ~pinSync);
			deviceReset <= regReset;
		end
	end
endmodule
`default_nettype wire

// *** pmr_regs.vh ***
// Constants for the management port, reset and shared pin block.
`ifndef PMR_REGS_VH
`define PMR_REGS_VH

`define PMR_REG_CTRL        5'h00
`define PMR_REG_STATUS      5'h01
`define PMR_REG_ID1         5'h02
`define PMR_REG_ID2         5'h03
`define PMR_REG_IRQ_MASK    5'h12
`define PMR_REG_IRQ_STAT    5'h13
`define PMR_REG_PIN_CFG     5'h1E

`define PMR_CTRL_SOFT_RST   15
`define PMR_CTRL_PWRDN      11
`define PMR_PIN_CFG_IRQ     0

`define PMR_CTRL_RESET      16'h0000
`define PMR_MASK_RESET      16'h0000
`define PMR_STAT_RESET      16'h0000
`define PMR_PIN_CFG_RESET   16'h0000

`define PMR_OP_WRITE        2'h1
`define PMR_OP_READ         2'h2

`define PMR_PREAMBLE_BITS   6'h20
`define PMR_HDR_LAST        6'h0B
`define PMR_TA_LAST         6'h01
`define PMR_DATA_LAST       6'h0F

`define PMR_MDC_MAX_KHZ     25000
`define PMR_CLK_PERIOD_NS   50
`define PMR_RST_MIN_NS      1000
`define PMR_RST_MIN_CYC     ((`PMR_RST_MIN_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)

`endif

// *** pmr_station.sv ***
// Management station model driving frames on the shared data line.
`timescale 1ns/1ps
`default_nettype none
module pmr_station (
	output logic      mdc,
	output logic      mdioDrv,
	output logic      mdioEn,
	input  wire logic mdio
);
	logic s;
	initial begin
		mdc = 1'b0;
		mdioDrv = 1'b1;
		mdioEn = 1'b0;
	end
	// Late sampling is safe since read data stands until the next fall.
	task automatic bitx(input logic en, input logic b);
		mdioEn = en;
		mdioDrv = b;
		#200 mdc = 1'b1;
		#150 s = mdio;
		#50 mdc = 1'b0;
	endtask
	task automatic xfer(input int pre, input logic [1:0] op,
		input logic [4:0] ad, ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [31:0] f;
		f = {2'b01, op, ad, ra, 2'b10, wd};
		for (int k = 0; k < pre; k++)
			bitx(1'b1, 1'b1);
		for (int i = 31; i >= 0; i--) begin
			bitx(op[0] || i > 17, f[i]);
			rd[i % 16] = s;
		end
		mdioEn = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** pmr_sync.v ***
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module pmr_sync #(
	parameter WIDTH     = 1,
	parameter RESET_VAL = 1'b0
) (
	input  wire             clk,
	input  wire             reset,
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk) begin
		if (reset) begin
			meta <= {WIDTH{RESET_VAL}};
			q    <= {WIDTH{RESET_VAL}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Top testbench for the management port and shared pin block.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_regs.vh"
module tb_top;
	localparam [4:0]  ADDR = 5'h05;
	localparam [15:0] ID1  = 16'hA5C3; // Arbitrary identity value.
	localparam [15:0] ID2  = 16'h3C5A; // Arbitrary identity value.
	localparam [15:0] STAT = 16'h2D4B;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        resetN = 1'b1;
	logic        pinLvl = 1'b1;
	logic [15:0] eventIn = 16'h0000;
	logic [15:0] v;
	int          n_fail = 0;
	int          n_checks = 0;
	wire logic   mdc, sDrv, sEn, dOut, dOe, pOut, pOe, pd, devRst;
	// The data line has a pull-up, so released it reads high; a released pin reads pinLvl.
	wire logic   mdio = dOe ? dOut : sEn ? sDrv : 1'b1;
	wire logic   pin = pOe ? pOut : pinLvl;
	pmr_mgmt_pins #(.ID1(ID1), .ID2(ID2)) i_pmr_mgmt_pins (.clk(clk),
		.reset(reset), .resetN(resetN), .phyAddr(ADDR), .mdc(mdc),
		.mdioIn(mdio), .mdioOut(dOut), .mdioOe(dOe),
		.irqOrSleepPinIn(pin), .irqOrSleepPinOut(pOut),
		.irqOrSleepPinOe(pOe), .statusIn(STAT), .eventIn(eventIn),
		.powerDown(pd), .deviceReset(devRst));
	pmr_station i_pmr_station (.mdc(mdc), .mdioDrv(sDrv), .mdioEn(sEn),
		.mdio(mdio));
	// The bench clock stands in for the board reference.
	always #25 clk = ~clk;
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chkB(input string nm, input logic e, input logic g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task rd(input logic [4:0] ra, output logic [15:0] d);
		i_pmr_station.xfer(32, `PMR_OP_READ, ADDR, ra, 16'h0000, d);
		tick(4);
	endtask
	task wr(input logic [4:0] ra, input logic [15:0] d);
		i_pmr_station.xfer(32, `PMR_OP_WRITE, ADDR, ra, d, v);
		tick(4);
	endtask
	task t_regs;
		logic [4:0]  ra [5];
		logic [15:0] ex [5];
		ra = '{5'h02, 5'h03, 5'h01, 5'h00, 5'h07};
		ex = '{ID1, ID2, STAT, 16'h0000, 16'h0000};
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], v);
			chk("reg", ex[i], v);
		end
		$display("t_regs done");
	endtask
	task t_refuse;
		for (int c = 0; c < 4; c++) begin
			i_pmr_station.xfer(c ? 32 : 31, c == 2 ? 2'h0 : c == 3 ? 2'h3
				: `PMR_OP_READ, c == 1 ? ADDR ^ 5'h01 : ADDR, 5'h02,
				16'hFFFF, v);
			chk("refused", 16'hFFFF, v);
			tick(4);
		end
		i_pmr_station.xfer(32, `PMR_OP_WRITE, ADDR ^ 5'h01, 5'h12,
			16'hFFFF, v);
		tick(4);
		rd(5'h12, v);
		chk("foreign write", 16'h0000, v);
		$display("t_refuse done");
	endtask
	task t_sleep;
		pinLvl = 1'b0;
		tick(6);
		chkB("sleep", 1'b1, pd);
		rd(5'h03, v);
		chk("asleep read", ID2, v);
		chkB("pin role", 1'b0, pOe);
		pinLvl = 1'b1;
		tick(6);
		chkB("awake", 1'b0, pd);
		$display("t_sleep done");
	endtask
	task t_irq;
		wr(5'h1E, 16'h0001);
		wr(5'h12, 16'h0001);
		pinLvl = 1'b0;
		tick(6);
		chkB("pin ignored", 1'b0, pd);
		pinLvl = 1'b1;
		for (int b = 1; b >= 0; b--) begin
			eventIn = 16'h0001 << b;
			tick(1);
			eventIn = 16'h0000;
			tick(4);
			chkB("irq pin", b[0], pin);
		end
		rd(5'h13, v);
		chk("irq status", 16'h0003, v);
		chkB("irq released", 1'b1, pin);
		$display("t_irq done");
	endtask
	task t_hwrst;
		resetN = 1'b0;
		tick(30);
		chkB("device reset", 1'b1, devRst);
		resetN = 1'b1;
		tick(8);
		rd(5'h1E, v);
		chk("pin config", `PMR_PIN_CFG_RESET, v);
		rd(5'h12, v);
		chk("mask", `PMR_MASK_RESET, v);
		$display("t_hwrst done");
	endtask
	task t_soft;
		wr(`PMR_REG_CTRL, 16'h0800);
		chkB("ctrl sleep", 1'b1, pd);
		rd(`PMR_REG_CTRL, v);
		chk("asleep ctrl", 16'h0800, v);
		wr(`PMR_REG_CTRL, 16'h8000);
		chkB("soft awake", 1'b0, pd);
		rd(`PMR_REG_CTRL, v);
		chk("soft reset", `PMR_CTRL_RESET, v);
		$display("t_soft done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		tick(3);
		reset = 1'b0;
		tick(6);
		t_regs;
		t_refuse;
		t_sleep;
		t_irq;
		t_hwrst;
		t_soft;
		wrap_up;
	end
	initial begin
		#2000000;
		n_fail++;
		wrap_up;
	end
endmodule
bind pmr_mgmt_pins pmr_mgmt_monitor i_pmr_mgmt_monitor (.clk, .reset,
	.resetN, .mdc, .mdioOut, .mdioOe, .irqOrSleepPinOut, .irqOrSleepPinOe,
	.eventIn, .powerDown, .deviceReset);
`default_nettype wire
